// ### hdl/sctl_pkg.sv
package sctl_pkg;

  // Register offsets
  localparam logic [7:0] SCTL_OFS_DEV_ADDR = 8'h00;
  localparam logic [7:0] SCTL_OFS_RESET    = 8'h01;
  localparam logic [7:0] SCTL_OFS_GEN_CFG  = 8'h03;

  // Registers outside this bank restored by the keep-registers reset
  localparam logic [7:0] SCTL_OFS_EXT_A  = 8'h18;
  localparam logic [7:0] SCTL_OFS_EXT_B  = 8'h19;
  localparam logic [7:0] SCTL_OFS_EXT_C  = 8'h1A;
  localparam logic [7:0] SCTL_OFS_EXT_LO = 8'h48;
  localparam logic [7:0] SCTL_OFS_EXT_HI = 8'h55;

  // Field positions
  localparam int SCTL_DEV_SRC_BIT   = 0;
  localparam int SCTL_DEV_ID_LSB    = 1;
  localparam int SCTL_RST_FULL_BIT  = 1;
  localparam int SCTL_RST_KEEP_BIT  = 0;
  localparam int SCTL_CFG_CRC_BIT   = 7;
  localparam int SCTL_CFG_AUTO_BIT  = 5;
  localparam int SCTL_CFG_FILT_BIT  = 4;
  localparam int SCTL_CFG_PASS_BIT  = 3;
  localparam int SCTL_CFG_PCLK_BIT  = 1;

  // Reset values
  localparam logic [7:0] SCTL_RESET_RST      = 8'h00;
  localparam logic [7:0] SCTL_GEN_CFG_RST    = 8'hD2;
  localparam logic [7:0] SCTL_GEN_CFG_RSV1   = 8'h40;
  localparam logic       SCTL_DEV_SRC_RST    = 1'b0;

  // Strap address table: base plus two per step
  localparam logic [6:0] SCTL_STRAP_BASE     = 7'h0C;
  localparam logic [6:0] SCTL_PORT1_OFFSET   = 7'h01;

  // Timing counts
  localparam int         SCTL_FILT_MIN_CYC   = 2;
  localparam logic [3:0] SCTL_BYTE_BITS      = 4'h8;

  typedef enum logic [6:0] {
    SCTL_ST_IDLE  = 7'b0000001,
    SCTL_ST_ADDR  = 7'b0000010,
    SCTL_ST_ACK   = 7'b0000100,
    SCTL_ST_PTR   = 7'b0001000,
    SCTL_ST_WDATA = 7'b0010000,
    SCTL_ST_RDATA = 7'b0100000,
    SCTL_ST_MACK  = 7'b1000000
  } sctl_i2c_state_t;

endpackage

// ### hdl/sctl_sync2.sv
`timescale 1ns/100ps
module sctl_sync2
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage.
  // Left out of reset so a strap is already settled while reset is held.
  always_ff @(posedge clk_sys)
  begin
    meta_r <= din;
    dout   <= meta_r;
  end

endmodule

// ### hdl/sctl_glitch_filter.sv
`timescale 1ns/100ps
module sctl_glitch_filter
  import sctl_pkg::*;
#(
  parameter int WIDTH   = 3,
  parameter int MIN_CYC = SCTL_FILT_MIN_CYC
)
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);

  localparam int CW = $clog2(MIN_CYC + 1);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic          q_r;
      logic          q_nxt;
      logic [CW-1:0] cnt_r;
      logic [CW-1:0] cnt_nxt;

      // A change is taken only once it has stood for MIN_CYC cycles
      always_comb
      begin
        q_nxt   = q_r;
        cnt_nxt = '0;
        if (reset)
          q_nxt = 1'b0;
        else if (!enable)
          q_nxt = din[i];
        else if (din[i] != q_r)
        begin
          if (cnt_r == CW'(MIN_CYC - 1))
            q_nxt = din[i];
          else
            cnt_nxt = cnt_r + CW'(1);
        end
      end

      always_ff @(posedge clk_sys)
      begin
        q_r   <= q_nxt;
        cnt_r <= cnt_nxt;
      end

      assign dout[i] = q_r;
    end
  endgenerate

endmodule

// ### hdl/sctl_serializer_ctrl.sv
// Function
// - Address register bits 7:1 hold device address, strap-loaded at reset.
// - With second-port bus enabled, second-port address defaults to strap plus one.
// - Second-port select steers per-port fields to the second port copy.
// - Address bit 0 picks strap address (0) or programmed field (1).
// - Reset bit 1 resets all logic and registers, then self-clears.
// - Reset bit 0 resets logic keeping most registers, then self-clears.
// - Partial reset also restores registers 0x18-0x1A and 0x48-0x55.
// - Configuration bit 7 enables back-channel CRC checker, default on.
// - Configuration bit 5 acknowledges remote deserializer writes at once.
// - With pass-all enabled, immediate acknowledge covers every remote slave.
// - Under auto-acknowledge, remote not-acknowledge reaches local host only on non-deserializer writes with pass-all off.
// - Configuration bit 4 rejects sync and enable pulses under two cycles.
// - Configuration bit 3 forwards alias-matching transactions to remote side.
// - Configuration bit 1 switches to internal oscillator without pixel clock.
// - Strap selects one of eight addresses, 0x0C to 0x1A step two.
// - Simultaneous local and remote register accesses are arbitrated safely.
`timescale 1ns/100ps
module sctl_serializer_ctrl
  import sctl_pkg::*;
#(
  parameter int FILTER_MIN_CYC = SCTL_FILT_MIN_CYC
)
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output      logic       sdaOut,
  output      logic       sdaOeN,
  input  wire logic [2:0] addressStrapInput,
  input  wire logic       secondPortBusEnable,
  input  wire logic       secondPortSelect,
  input  wire logic       pixelClkPresent,
  input  wire logic       dataEnableInput,
  input  wire logic       horizontalSync,
  input  wire logic       verticalSync,
  output      logic       dataEnableOut,
  output      logic       horizontalSyncOut,
  output      logic       verticalSyncOut,
  input  wire logic       remReq,
  input  wire logic       remWrite,
  input  wire logic [7:0] remAddr,
  input  wire logic [7:0] remWdata,
  output      logic       remAck,
  output      logic [7:0] remRdata,
  input  wire logic       fwdWriteStart,
  input  wire logic       fwdToDeser,
  input  wire logic       passAllEnable,
  input  wire logic       remoteAck,
  input  wire logic       remoteNack,
  output      logic       hostAck,
  output      logic       hostNack,
  output      logic [6:0] deviceAddress,
  output      logic [6:0] secondPortAddress,
  output      logic       crcCheckEnable,
  output      logic [1:0] autoAckEnable,
  output      logic [1:0] passThroughEnable,
  output      logic       useInternalOsc,
  output      logic       coreReset,
  output      logic       regFileReset,
  output      logic       extDefaultsReload
);

  logic            sclS;
  logic            sdaS;
  logic [2:0]      strapS;
  logic            pclkS;
  logic            sclD_r;
  logic            sdaD_r;
  logic            sclRise;
  logic            sclFall;
  logic            startCond;
  logic            stopCond;
  sctl_i2c_state_t st_r;
  sctl_i2c_state_t st_nxt;
  sctl_i2c_state_t ret_r;
  sctl_i2c_state_t ret_nxt;
  logic [3:0]      cnt_r;
  logic [3:0]      cnt_nxt;
  logic [7:0]      shift_r;
  logic [7:0]      shift_nxt;
  logic [7:0]      ptr_r;
  logic [7:0]      ptr_nxt;
  logic            drv_r;
  logic            drv_nxt;
  logic            locWr;
  logic [7:0]      locRdByte;
  logic            remGrant;
  logic            wrEn;
  logic [7:0]      wrAddr;
  logic [7:0]      wrData;
  logic            portSel;
  logic [6:0]      strapAddr;
  logic [6:0]      strapAddrP1;
  logic [6:0]      devId_r [2];
  logic [6:0]      devId_nxt [2];
  logic            idSel_r;
  logic            idSel_nxt;
  logic [1:0]      rst_r;
  logic [1:0]      rst_nxt;
  logic            crcEn_r;
  logic            crcEn_nxt;
  logic [1:0]      autoAck_r;
  logic [1:0]      autoAck_nxt;
  logic            filtEn_r;
  logic            filtEn_nxt;
  logic [1:0]      pass_r;
  logic [1:0]      pass_nxt;
  logic            pclkAuto_r;
  logic            pclkAuto_nxt;
  logic            remAck_nxt;
  logic [7:0]      remRdata_nxt;
  logic            autoSel;
  logic            pend_r;
  logic            pend_nxt;
  logic            hostAck_nxt;
  logic            hostNack_nxt;
  logic [6:0]      devAddr_nxt;
  logic            intOsc_nxt;

  sctl_sync2
  #(
    .WIDTH   (6),
    .RST_VAL (6'h03)
  )
  u_sync
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     ({pixelClkPresent, addressStrapInput, sdaIn, sclIn}),
    .dout    ({pclkS, strapS, sdaS, sclS})
  );

  sctl_glitch_filter
  #(
    .WIDTH   (3),
    .MIN_CYC (FILTER_MIN_CYC)
  )
  u_filter
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .enable  (filtEn_r),
    .din     ({dataEnableInput, horizontalSync, verticalSync}),
    .dout    ({dataEnableOut, horizontalSyncOut, verticalSyncOut})
  );

  function automatic logic [7:0] readReg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      SCTL_OFS_DEV_ADDR: v = {devId_r[portSel], idSel_r};
      SCTL_OFS_RESET:    v = {6'h00, rst_r};
      SCTL_OFS_GEN_CFG:
      begin
        v[SCTL_CFG_CRC_BIT]  = crcEn_r;
        v[SCTL_CFG_AUTO_BIT] = autoAck_r[portSel];
        v[SCTL_CFG_FILT_BIT] = filtEn_r;
        v[SCTL_CFG_PASS_BIT] = pass_r[portSel];
        v[SCTL_CFG_PCLK_BIT] = pclkAuto_r;
        v = v | SCTL_GEN_CFG_RSV1;
      end
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  assign portSel     = secondPortSelect;
  assign strapAddr   = 7'(SCTL_STRAP_BASE + {3'b000, strapS, 1'b0});
  assign strapAddrP1 = secondPortBusEnable ? 7'(strapAddr + SCTL_PORT1_OFFSET)
                                           : strapAddr;
  assign sclRise   = sclS & ~sclD_r;
  assign sclFall   = ~sclS & sclD_r;
  assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
  assign stopCond  = sclS & sclD_r & ~sdaD_r & sdaS;
  assign locRdByte = readReg(ptr_r);

  always_ff @(posedge clk_sys)
  begin
    sclD_r <= sclS;
    sdaD_r <= sdaS;
  end

  // Bus slave: pointer byte first, then data bytes auto-incrementing.
  // Held only by the pin reset so a soft reset cannot cut an ACK short.
  always_comb
  begin
    st_nxt    = st_r;
    ret_nxt   = ret_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt   = ptr_r;
    drv_nxt   = drv_r;
    locWr     = 1'b0;
    if (reset)
    begin
      st_nxt  = SCTL_ST_IDLE;
      ret_nxt = SCTL_ST_IDLE;
      cnt_nxt = 4'h0;
      ptr_nxt = 8'h00;
      drv_nxt = 1'b0;
    end
    else if (startCond)
    begin
      st_nxt  = SCTL_ST_ADDR;
      cnt_nxt = 4'h0;
      drv_nxt = 1'b0;
    end
    else if (stopCond)
    begin
      st_nxt  = SCTL_ST_IDLE;
      drv_nxt = 1'b0;
    end
    else
    begin
      unique case (st_r)
        SCTL_ST_IDLE:
          st_nxt = SCTL_ST_IDLE;
        SCTL_ST_ADDR, SCTL_ST_PTR, SCTL_ST_WDATA:
          if (sclRise)
          begin
            shift_nxt = {shift_r[6:0], sdaS};
            cnt_nxt   = cnt_r + 4'h1;
          end
          else if (sclFall && cnt_r == SCTL_BYTE_BITS)
          begin
            cnt_nxt = 4'h0;
            st_nxt  = SCTL_ST_ACK;
            drv_nxt = 1'b1;
            ret_nxt = SCTL_ST_WDATA;
            if (st_r == SCTL_ST_ADDR)
            begin
              if (shift_r[7:1] != deviceAddress)
              begin
                st_nxt  = SCTL_ST_IDLE;
                drv_nxt = 1'b0;
              end
              else if (shift_r[0])
                ret_nxt = SCTL_ST_RDATA;
              else
                ret_nxt = SCTL_ST_PTR;
            end
            else if (st_r == SCTL_ST_PTR)
              ptr_nxt = shift_r;
            else
            begin
              locWr   = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        SCTL_ST_ACK:
          if (sclFall)
          begin
            st_nxt  = ret_r;
            drv_nxt = 1'b0;
            if (ret_r == SCTL_ST_RDATA)
            begin
              shift_nxt = locRdByte;
              drv_nxt   = ~locRdByte[7];
              cnt_nxt   = 4'h1;
              ptr_nxt   = ptr_r + 8'h01;
            end
          end
        SCTL_ST_RDATA:
          if (sclFall)
          begin
            if (cnt_r == SCTL_BYTE_BITS)
            begin
              drv_nxt = 1'b0;
              st_nxt  = SCTL_ST_MACK;
            end
            else
            begin
              drv_nxt   = ~shift_r[6];
              shift_nxt = {shift_r[6:0], 1'b0};
              cnt_nxt   = cnt_r + 4'h1;
            end
          end
        SCTL_ST_MACK:
          if (sclRise && sdaS)
            st_nxt = SCTL_ST_IDLE;
          else if (sclFall)
          begin
            st_nxt    = SCTL_ST_RDATA;
            shift_nxt = locRdByte;
            drv_nxt   = ~locRdByte[7];
            cnt_nxt   = 4'h1;
            ptr_nxt   = ptr_r + 8'h01;
          end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    st_r    <= st_nxt;
    ret_r   <= ret_nxt;
    cnt_r   <= cnt_nxt;
    shift_r <= shift_nxt;
    ptr_r   <= ptr_nxt;
    drv_r   <= drv_nxt;
  end

  assign sdaOut = 1'b0;
  assign sdaOeN = ~drv_r;

  // Local write wins the cycle; a remote request simply waits one more
  assign remGrant = remReq & ~locWr & ~remAck;
  assign wrEn     = locWr | (remGrant & remWrite);
  assign wrAddr   = locWr ? ptr_r : remAddr;
  assign wrData   = locWr ? shift_r : remWdata;

  always_comb
  begin
    remAck_nxt   = remGrant;
    remRdata_nxt = remRdata;
    if (remGrant && !remWrite)
      remRdata_nxt = readReg(remAddr);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      remAck   <= 1'b0;
      remRdata <= 8'h00;
    end
    else
    begin
      remAck   <= remAck_nxt;
      remRdata <= remRdata_nxt;
    end
  end

  // Register bank
  always_comb
  begin
    devId_nxt    = devId_r;
    idSel_nxt    = idSel_r;
    rst_nxt      = SCTL_RESET_RST[1:0];
    crcEn_nxt    = crcEn_r;
    autoAck_nxt  = autoAck_r;
    filtEn_nxt   = filtEn_r;
    pass_nxt     = pass_r;
    pclkAuto_nxt = pclkAuto_r;
    if (wrEn)
    begin
      unique case (wrAddr)
        SCTL_OFS_DEV_ADDR:
        begin
          devId_nxt[portSel] = wrData[7:SCTL_DEV_ID_LSB];
          idSel_nxt          = wrData[SCTL_DEV_SRC_BIT];
        end
        SCTL_OFS_RESET:
          rst_nxt = {wrData[SCTL_RST_FULL_BIT], wrData[SCTL_RST_KEEP_BIT]};
        SCTL_OFS_GEN_CFG:
        begin
          crcEn_nxt          = wrData[SCTL_CFG_CRC_BIT];
          autoAck_nxt[portSel] = wrData[SCTL_CFG_AUTO_BIT];
          filtEn_nxt         = wrData[SCTL_CFG_FILT_BIT];
          pass_nxt[portSel]  = wrData[SCTL_CFG_PASS_BIT];
          pclkAuto_nxt       = wrData[SCTL_CFG_PCLK_BIT];
        end
        default:
          idSel_nxt = idSel_r;
      endcase
    end
    if (reset || rst_r[SCTL_RST_FULL_BIT])
    begin
      devId_nxt[0] = strapAddr;
      devId_nxt[1] = strapAddrP1;
      idSel_nxt    = SCTL_DEV_SRC_RST;
      rst_nxt      = SCTL_RESET_RST[1:0];
      crcEn_nxt    = SCTL_GEN_CFG_RST[SCTL_CFG_CRC_BIT];
      autoAck_nxt  = {2{SCTL_GEN_CFG_RST[SCTL_CFG_AUTO_BIT]}};
      filtEn_nxt   = SCTL_GEN_CFG_RST[SCTL_CFG_FILT_BIT];
      pass_nxt     = {2{SCTL_GEN_CFG_RST[SCTL_CFG_PASS_BIT]}};
      pclkAuto_nxt = SCTL_GEN_CFG_RST[SCTL_CFG_PCLK_BIT];
    end
    else if (rst_r[SCTL_RST_KEEP_BIT])
    begin
      devId_nxt[0] = strapAddr;
      devId_nxt[1] = strapAddrP1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    devId_r    <= devId_nxt;
    idSel_r    <= idSel_nxt;
    rst_r      <= rst_nxt;
    crcEn_r    <= crcEn_nxt;
    autoAck_r  <= autoAck_nxt;
    filtEn_r   <= filtEn_nxt;
    pass_r     <= pass_nxt;
    pclkAuto_r <= pclkAuto_nxt;
  end

  // Early acknowledge trades throughput for losing the remote answer
  assign autoSel = autoAck_r[portSel] & (fwdToDeser | passAllEnable);

  always_comb
  begin
    pend_nxt     = pend_r;
    hostAck_nxt  = 1'b0;
    hostNack_nxt = 1'b0;
    if (reset)
      pend_nxt = 1'b0;
    else if (fwdWriteStart)
    begin
      hostAck_nxt = autoSel;
      pend_nxt    = ~autoSel;
    end
    else if (pend_r && (remoteAck || remoteNack))
    begin
      pend_nxt     = 1'b0;
      hostAck_nxt  = remoteAck;
      hostNack_nxt = remoteNack & ~remoteAck;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    pend_r   <= pend_nxt;
    hostAck  <= hostAck_nxt;
    hostNack <= hostNack_nxt;
  end

  assign devAddr_nxt = idSel_r ? devId_r[0] : strapAddr;
  assign intOsc_nxt  = pclkAuto_r & ~pclkS;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      deviceAddress     <= SCTL_STRAP_BASE;
      useInternalOsc    <= 1'b0;
      coreReset         <= 1'b1;
      regFileReset      <= 1'b1;
      extDefaultsReload <= 1'b0;
    end
    else
    begin
      deviceAddress     <= devAddr_nxt;
      useInternalOsc    <= intOsc_nxt;
      coreReset         <= |rst_r;
      regFileReset      <= rst_r[SCTL_RST_FULL_BIT];
      extDefaultsReload <= rst_r[SCTL_RST_KEEP_BIT];
    end
  end

  assign secondPortAddress = devId_r[1];
  assign crcCheckEnable    = crcEn_r;
  assign autoAckEnable     = autoAck_r;
  assign passThroughEnable = pass_r;

endmodule

// ### bench/sctl_ctrl_properties.sv
`timescale 1ns/100ps
module sctl_ctrl_properties
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic remReq,
  input wire logic remAck,
  input wire logic fwdWriteStart,
  input wire logic remoteAck,
  input wire logic remoteNack,
  input wire logic hostAck,
  input wire logic hostNack,
  input wire logic pixelClkPresent,
  input wire logic useInternalOsc,
  input wire logic coreReset,
  input wire logic regFileReset,
  input wire logic extDefaultsReload,
  input wire logic dataEnableInput,
  input wire logic dataEnableOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_rem_ack_bound: assert property (remReq && !remAck |-> ##[1:2] remAck)
    else $error("remote access not answered in time");
  a_rem_ack_pulse: assert property (remAck |=> !remAck)
    else $error("remote acknowledge longer than one cycle");
  a_host_ack_cause: assert property (hostAck |-> $past(fwdWriteStart) || $past(remoteAck))
    else $error("host acknowledge without cause");
  a_host_nack_cause: assert property (hostNack |-> $past(remoteNack) && !hostAck)
    else $error("host not-acknowledge without remote one");
  a_full_reset_pulse: assert property ($rose(regFileReset) |-> coreReset ##1 !regFileReset)
    else $error("register reset not a one-cycle pulse");
  a_keep_reset_pulse: assert property ($rose(extDefaultsReload) |->
    coreReset && !regFileReset ##1 !extDefaultsReload)
    else $error("default reload not a one-cycle pulse");
  a_osc_stays_off: assert property (pixelClkPresent [*3] |=> !useInternalOsc)
    else $error("internal oscillator used with pixel clock present");
  a_filter_drops_short: assert property (!dataEnableInput [*4] ##1 dataEnableInput
    ##1 !dataEnableInput [*4] |-> !dataEnableOut)
    else $error("one-cycle enable pulse passed the filter");
endmodule

bind sctl_serializer_ctrl sctl_ctrl_properties u_props
(
  .clk_sys(clk_sys), .reset(reset), .remReq(remReq), .remAck(remAck),
  .fwdWriteStart(fwdWriteStart), .remoteAck(remoteAck), .remoteNack(remoteNack),
  .hostAck(hostAck), .hostNack(hostNack), .pixelClkPresent(pixelClkPresent),
  .useInternalOsc(useInternalOsc), .coreReset(coreReset), .regFileReset(regFileReset),
  .extDefaultsReload(extDefaultsReload), .dataEnableInput(dataEnableInput),
  .dataEnableOut(dataEnableOut)
);

// ### bench/sctl_i2c_host.sv
`timescale 1ns/100ps
module sctl_i2c_host
(
  input  wire logic clk_sys,
  input  wire logic sdaWire,
  output      logic scl,
  output      logic sdaRel
);
  initial
  begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Data moves two cycles after the clock falls, so it is never read as START or STOP
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sdaRel <= b;
    tick(6);
    scl <= 1'b1;
    tick(6);
    r = sdaWire;
    scl <= 1'b0;
  endtask

  task automatic start();
    tick(2);
    sdaRel <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sdaRel <= 1'b0;
    tick(6);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sdaRel <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sdaRel <= 1'b1;
    tick(6);
  endtask

  task automatic xfer(input logic [7:0] d, input logic nb, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q = {q[6:0], r};
    end
    bit_io(nb, a);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, d, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start();
    xfer({dev, 1'b0}, 1'b1, q, a0);
    xfer(ofs, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  // Last byte refused by the host to end the read
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start();
    xfer({dev, 1'b0}, 1'b1, q, a0);
    xfer(ofs, 1'b1, q, a1);
    start();
    xfer({dev, 1'b1}, 1'b1, q, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/100ps
module tb
  import sctl_pkg::*;
;
  localparam logic [6:0] STRAP = SCTL_STRAP_BASE + 7'h06;
  localparam logic [6:0] PROG  = 7'h30;
  logic       clk_sys = 1'b0;
  logic       reset   = 1'b1;
  logic       p1Sel   = 1'b0;
  logic       p1En    = 1'b1;
  logic       pclkOk  = 1'b1;
  logic       de      = 1'b0;
  logic       hs      = 1'b0;
  logic       remReq  = 1'b0;
  logic       remWr   = 1'b0;
  logic [7:0] remA    = 8'h00;
  logic [7:0] remD    = 8'h00;
  logic       fwdGo   = 1'b0;
  logic       toDes   = 1'b0;
  logic       passAll = 1'b0;
  logic       remNack = 1'b0;
  logic       remOk   = 1'b0;
  logic       sclIn, sdaIn, sdaOut, sdaOeN, sdaRel, deO, hsO, vsO, remAck, hAck, hNack;
  logic       intOsc, crcEn;
  logic [1:0] autoAck, passEn;
  logic [6:0] devAddr, p1Addr;
  logic [7:0] remQ, q, remRdata_w;
  int         mismatches = 0;
  int         checkCount = 0;

  always #2.5 clk_sys = ~clk_sys;
  // Open-drain wire with pull-up: low when either side pulls
  assign sdaIn = sdaRel & (sdaOeN | sdaOut);

  sctl_i2c_host host (.clk_sys(clk_sys), .sdaWire(sdaIn), .scl(sclIn), .sdaRel(sdaRel));

  sctl_serializer_ctrl dut
  (
    .clk_sys(clk_sys), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .addressStrapInput(3'h3), .secondPortBusEnable(p1En),
    .secondPortSelect(p1Sel), .pixelClkPresent(pclkOk), .dataEnableInput(de),
    .horizontalSync(hs), .verticalSync(hs), .dataEnableOut(deO),
    .horizontalSyncOut(hsO), .verticalSyncOut(vsO), .remReq(remReq), .remWrite(remWr),
    .remAddr(remA), .remWdata(remD), .remAck(remAck), .remRdata(remRdata_w),
    .fwdWriteStart(fwdGo), .fwdToDeser(toDes), .passAllEnable(passAll),
    .remoteAck(remOk), .remoteNack(remNack), .hostAck(hAck), .hostNack(hNack),
    .deviceAddress(devAddr), .secondPortAddress(p1Addr), .crcCheckEnable(crcEn),
    .autoAckEnable(autoAck), .passThroughEnable(passEn), .useInternalOsc(intOsc),
    .coreReset(), .regFileReset(), .extDefaultsReload()
  );

  task automatic chk(input logic [7:0] got, exp);
    checkCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rr(input logic [6:0] dev, input logic [7:0] ofs, exp);
    logic [7:0] d;
    logic       ok;
    host.rd(dev, ofs, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask

  task automatic ww(input logic [6:0] dev, input logic [7:0] ofs, d);
    logic ok;
    host.wr(dev, ofs, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic rem(input logic w, input logic [7:0] a, d);
    int n;
    n = 0;
    remReq <= 1'b1;
    remWr <= w;
    remA <= a;
    remD <= d;
    do @(posedge clk_sys); while (remAck !== 1'b1 && ++n < 8);
    chk({7'h00, remAck}, 8'h01);
    remQ = remRdata_w;
    remReq <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Remote side answers (ack if ra, else refuse) one cycle after the write starts
  task automatic fwd(input logic td, pa, ra, input logic [7:0] exp);
    logic [1:0] seen;
    fwdGo <= 1'b1;
    toDes <= td;
    passAll <= pa;
    @(posedge clk_sys);
    fwdGo <= 1'b0;
    remNack <= ~ra;
    remOk <= ra;
    @(posedge clk_sys);
    seen = {hNack, hAck};
    remNack <= 1'b0;
    remOk <= 1'b0;
    repeat (4) @(posedge clk_sys) seen |= {hNack, hAck};
    chk({6'h00, seen}, exp);
  endtask

  function automatic logic [7:0] cfg_view();
    return {crcEn, intOsc, autoAck, passEn, 2'b00};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({1'b0, devAddr}, {1'b0, STRAP});
    chk({1'b0, p1Addr}, {1'b0, STRAP + SCTL_PORT1_OFFSET});
    chk(cfg_view(), 8'h80);
    rr(STRAP, SCTL_OFS_DEV_ADDR, {STRAP, 1'b0});
    rr(STRAP, SCTL_OFS_RESET, SCTL_RESET_RST);
    rr(STRAP, SCTL_OFS_GEN_CFG, SCTL_GEN_CFG_RST);
    rr(STRAP, 8'h02, 8'h00);
    $display("test reset defaults done");
    ww(STRAP, SCTL_OFS_GEN_CFG, 8'h10);
    rr(STRAP, SCTL_OFS_GEN_CFG, 8'h50);
    ww(STRAP, SCTL_OFS_GEN_CFG, 8'hFF);
    rr(STRAP, SCTL_OFS_GEN_CFG, 8'hFA);
    chk(cfg_view(), 8'h94);
    $display("test configuration done");
    fwd(1'b1, 1'b0, 1'b0, 8'h01);
    fwd(1'b0, 1'b1, 1'b0, 8'h01);
    fwd(1'b0, 1'b0, 1'b0, 8'h02);
    fwd(1'b0, 1'b0, 1'b1, 8'h01);
    $display("test forward acknowledge done");
    p1Sel <= 1'b1;
    ww(STRAP, SCTL_OFS_GEN_CFG, 8'h30);
    rr(STRAP, SCTL_OFS_GEN_CFG, 8'h70);
    p1Sel <= 1'b0;
    rr(STRAP, SCTL_OFS_GEN_CFG, 8'h78);
    chk(cfg_view(), 8'h34);
    $display("test second port done");
    ww(STRAP, SCTL_OFS_DEV_ADDR, {PROG, 1'b1});
    chk({1'b0, devAddr}, {1'b0, PROG});
    rr(PROG, SCTL_OFS_DEV_ADDR, {PROG, 1'b1});
    ww(PROG, SCTL_OFS_RESET, 8'h01);
    chk({1'b0, devAddr}, {1'b0, STRAP});
    chk({1'b0, p1Addr}, {1'b0, STRAP + SCTL_PORT1_OFFSET});
    rr(STRAP, SCTL_OFS_DEV_ADDR, {STRAP, 1'b1});
    rr(STRAP, SCTL_OFS_GEN_CFG, 8'h78);
    rr(STRAP, SCTL_OFS_RESET, 8'h00);
    ww(STRAP, SCTL_OFS_RESET, 8'h02);
    rr(STRAP, SCTL_OFS_GEN_CFG, SCTL_GEN_CFG_RST);
    rr(STRAP, SCTL_OFS_DEV_ADDR, {STRAP, 1'b0});
    rr(STRAP, SCTL_OFS_RESET, 8'h00);
    p1En <= 1'b0;
    ww(STRAP, SCTL_OFS_RESET, 8'h01);
    chk({1'b0, p1Addr}, {1'b0, STRAP});
    p1En <= 1'b1;
    $display("test soft resets done");
    rem(1'b0, SCTL_OFS_GEN_CFG, 8'h00);
    chk(remQ, SCTL_GEN_CFG_RST);
    rem(1'b1, SCTL_OFS_GEN_CFG, 8'h12);
    rem(1'b0, SCTL_OFS_GEN_CFG, 8'h00);
    chk(remQ, 8'h52);
    rr(STRAP, SCTL_OFS_GEN_CFG, 8'h52);
    $display("test remote access done");
    de <= 1'b1;
    @(posedge clk_sys);
    de <= 1'b0;
    hs <= 1'b1;
    q = 8'h00;
    repeat (7) @(posedge clk_sys) q[0] |= deO;
    chk(q, 8'h00);
    chk({6'h00, hsO, vsO}, 8'h03);
    hs <= 1'b0;
    pclkOk <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk({7'h00, intOsc}, 8'h01);
    pclkOk <= 1'b1;
    repeat (5) @(posedge clk_sys);
    $display("test filter and oscillator done");
    report_and_stop();
  end
endmodule
